// [src/ccr_defines.vh]
// register offsets, field positions and reset values for the clock ratio block
// assumes a 32-bit axi4-lite slave with word-aligned registers
`ifndef CCR_DEFINES_VH
`define CCR_DEFINES_VH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define CCR_OFS_OUT_CLK_CTRL 4'h0
`define CCR_OFS_STATUS 4'h4
`define CCR_OFS_RATIO 4'h8

// ----------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------
`define CCR_ST_HOST_BIT 0
`define CCR_ST_HALVE_BIT 1
`define CCR_ST_VALID_BIT 2
`define CCR_ST_LOCK_BIT 3

// ----------------------------------------------------------------
// ratio register fields
// ----------------------------------------------------------------
`define CCR_RT_PMF_LSB 0
`define CCR_RT_CSB_LSB 8
`define CCR_RT_CORE_LSB 16

// ----------------------------------------------------------------
// reset values, codes, counts
// ----------------------------------------------------------------
`define CCR_OCC_RESET 8'h00
`define CCR_RESP_OKAY 2'b00
`define CCR_RESP_SLVERR 2'b10
`define CCR_PMF_LOW_MIN 4'h6
`define CCR_PMF_LOW_WRAP 4'h0
`define CCR_RATIO_WRAP 5'h10
`define CCR_PMF_HIGH_MIN 4'h2
`define CCR_PMF_HIGH_MAX 4'h8
`define CCR_LOCK_CYCLES 5'h10

`endif

// [src/ccr_clock_ratio.v]
// clock source selection, bus clock dividers and ratio configuration
// assumes all pins synchronous to core_clk; the ref clocks are sampled
// as levels, so they must run well below half of core_clk
`timescale 1ns/10ps
`include "ccr_defines.vh"

// Summary of operation
// - host mode uses the primary oscillator, agent mode the agent clock
// - in host mode the primary input feeds halver and output muxes
// - sync feedback output carries full or half clock per halving strap
// - each bus clock output picks full or half per its divide select bit
// - strap low: multiplier codes 6..15 give 6..15, code 0 gives 16
// - strap high: codes 2..8 give ratios 4 through 16 in steps of two
// - core clock ratio comes from the reset configuration core field
// - core clock generator locks as a slave to the bus clock
module ccr_clock_ratio #(
    parameter NBUS = 5,
    parameter CORE_W = 7
) (
    input wire core_clk,
    input wire reset,
    input wire host_mode_strap,
    input wire primary_osc_input,
    input wire agent_clk_input,
    input wire input_halving_strap,
    input wire [3:0] platform_multiplier_field,
    input wire [CORE_W-1:0] core_ratio_field,
    output reg sync_feedback_out_r,
    output reg [NBUS-1:0] bus_clk_out_r,
    output reg [4:0] csb_ratio_r,
    output reg [CORE_W-1:0] core_ratio_r,
    output reg core_locked_r,
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);

    // ------------------------------------------------------------
    // ratio decode
    // ------------------------------------------------------------
    function [4:0] ccr_csb_ratio;
        input halve;
        input [3:0] pmf;
        begin
            ccr_csb_ratio = 5'h00;
            if (!halve) begin
                if (pmf >= `CCR_PMF_LOW_MIN)
                    ccr_csb_ratio = {1'b0, pmf};
                else if (pmf == `CCR_PMF_LOW_WRAP)
                    ccr_csb_ratio = `CCR_RATIO_WRAP;
            end else if (pmf >= `CCR_PMF_HIGH_MIN &&
                         pmf <= `CCR_PMF_HIGH_MAX) begin
                ccr_csb_ratio = {pmf, 1'b0};
            end
        end
    endfunction

    // ------------------------------------------------------------
    // latched configuration
    // ------------------------------------------------------------
    reg host_r;
    reg halve_r;
    reg [3:0] pmf_r;
    reg [4:0] lock_cnt_r;
    reg [NBUS-1:0] occ_r;
    // reset pattern is one byte wide, so NBUS must stay at 8 or below
    wire [7:0] occ_rst = `CCR_OCC_RESET;

    // sampled every cycle of reset so the last level before release wins
    always @(posedge core_clk) begin
        if (reset) begin
            host_r <= host_mode_strap;
            halve_r <= input_halving_strap;
            pmf_r <= platform_multiplier_field;
            core_ratio_r <= core_ratio_field;
            csb_ratio_r <= ccr_csb_ratio(input_halving_strap,
                                         platform_multiplier_field);
        end
    end

    // lock waits on a valid bus ratio; unlisted core codes are not checked
    always @(posedge core_clk) begin
        if (reset) begin
            lock_cnt_r <= 5'h00;
            core_locked_r <= 1'b0;
        end else if (csb_ratio_r != 5'h00) begin
            if (lock_cnt_r == `CCR_LOCK_CYCLES)
                core_locked_r <= 1'b1;
            else
                lock_cnt_r <= lock_cnt_r + 5'h01;
        end
    end

    // ------------------------------------------------------------
    // source select and halving
    // ------------------------------------------------------------
    reg ref_r;
    reg ref_d_r;
    reg half_r;
    wire ref_nxt = host_r ? primary_osc_input : agent_clk_input;

    // reference pipe runs through reset too: a cleared stage would turn
    // a reference already high at release into a false rising edge
    always @(posedge core_clk) begin
        ref_r <= ref_nxt;
        ref_d_r <= ref_r;
        if (reset)
            half_r <= 1'b0;
        else if (ref_r && !ref_d_r)
            half_r <= ~half_r;
    end

    always @(posedge core_clk) begin
        if (reset)
            sync_feedback_out_r <= 1'b0;
        else
            sync_feedback_out_r <= halve_r ? half_r : ref_d_r;
    end

    // ------------------------------------------------------------
    // bus clock outputs
    // ------------------------------------------------------------
    // one mux per output; a divide select bit of 1 picks the half clock
    wire [NBUS-1:0] bus_clk_nxt;
    genvar gi;
    generate
        for (gi = 0; gi < NBUS; gi = gi + 1) begin : g_bus
            assign bus_clk_nxt[gi] = occ_r[gi] ? half_r : ref_d_r;
        end
    endgenerate

    // whole vector in one process, so each output bit has one driver
    always @(posedge core_clk) begin
        if (reset)
            bus_clk_out_r <= {NBUS{1'b0}};
        else
            bus_clk_out_r <= bus_clk_nxt;
    end

    // ------------------------------------------------------------
    // axi4-lite slave
    // ------------------------------------------------------------
    // one write and one read at a time; a pending response blocks a take
    wire wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid &&
                 !s_axi_awready;
    wire rd_go = s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
    wire [31:0] st_word = {28'h0000000, core_locked_r,
                           (csb_ratio_r != 5'h00), halve_r, host_r};
    wire [31:0] rt_word = {{(16 - CORE_W){1'b0}}, core_ratio_r,
                           3'h0, csb_ratio_r, 4'h0, pmf_r};

    always @(posedge core_clk) begin
        if (reset) begin
            occ_r <= occ_rst[NBUS-1:0];
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `CCR_RESP_OKAY;
        end else begin
            s_axi_awready <= wr_go;
            s_axi_wready <= wr_go;
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                if (s_axi_awaddr == `CCR_OFS_OUT_CLK_CTRL) begin
                    s_axi_bresp <= `CCR_RESP_OKAY;
                    if (s_axi_wstrb[0])
                        occ_r <= s_axi_wdata[NBUS-1:0];
                end else if (s_axi_awaddr == `CCR_OFS_STATUS ||
                             s_axi_awaddr == `CCR_OFS_RATIO) begin
                    s_axi_bresp <= `CCR_RESP_OKAY;
                end else begin
                    s_axi_bresp <= `CCR_RESP_SLVERR;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always @(posedge core_clk) begin
        if (reset) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `CCR_RESP_OKAY;
        end else begin
            s_axi_arready <= rd_go;
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `CCR_RESP_OKAY;
                if (s_axi_araddr == `CCR_OFS_OUT_CLK_CTRL)
                    s_axi_rdata <= {{(32 - NBUS){1'b0}}, occ_r};
                else if (s_axi_araddr == `CCR_OFS_STATUS)
                    s_axi_rdata <= st_word;
                else if (s_axi_araddr == `CCR_OFS_RATIO)
                    s_axi_rdata <= rt_word;
                else begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= `CCR_RESP_SLVERR;
                end
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

// [verification/ccr_chk_assertions.sv]
// checker: ratio latching, lock timing and reference clock selection
// assumes binding into ccr_clock_ratio; straps steady while in reset
`timescale 1ns/10ps
module ccr_chk #(
    parameter CORE_W = 7
) (
    input wire core_clk,
    input wire reset,
    input wire host_mode_strap,
    input wire input_halving_strap,
    input wire [3:0] platform_multiplier_field,
    input wire [CORE_W-1:0] core_ratio_field,
    input wire sync_feedback_out_r,
    input wire [4:0] csb_ratio_r,
    input wire [CORE_W-1:0] core_ratio_r,
    input wire core_locked_r
);
    reg [3:0] up_r;
    reg host_r;
    reg halve_r;
    // own copy of the latched straps: the pins move after release
    always @(posedge core_clk) begin
        up_r <= reset ? 4'h0 : up_r + {3'h0, up_r != 4'hf};
        host_r <= reset ? host_mode_strap : host_r;
        halve_r <= reset ? input_halving_strap : halve_r;
    end
    function [4:0] ratio(input h, input [3:0] p);
        if (h)
            ratio = (p >= 4'h2 && p <= 4'h8) ? {p, 1'h0} : 5'h00;
        else
            ratio = p >= 4'h6 ? {1'h0, p} : {p == 4'h0, 4'h0};
    endfunction
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    sequence lock_s;
        !core_locked_r [*8] ##[10:12] core_locked_r;
    endsequence
    ratio_low_a: assert property (
        $fell(reset) && !$past(input_halving_strap) |-> csb_ratio_r ==
        ratio(1'h0, $past(platform_multiplier_field))) else $error("low");
    ratio_high_a: assert property (
        $fell(reset) && $past(input_halving_strap) |-> csb_ratio_r ==
        ratio(1'h1, $past(platform_multiplier_field))) else $error("high");
    core_latch_a: assert property (
        $fell(reset) |-> core_ratio_r == $past(core_ratio_field))
        else $error("core ratio");
    ratio_hold_a: assert property (
        !$fell(reset) |-> $stable(csb_ratio_r) && $stable(core_ratio_r))
        else $error("ratio moved");
    lock_time_a: assert property (
        $fell(reset) && csb_ratio_r != 5'h00 |-> lock_s) else $error("lock");
    no_lock_a: assert property (
        csb_ratio_r == 5'h00 |-> !core_locked_r) else $error("false lock");
    sync_full_a: assert property (
        up_r >= 4'ha && !halve_r && $changed(sync_feedback_out_r) |=>
        if (host_r) ($stable(sync_feedback_out_r) [*3] ##1
        $changed(sync_feedback_out_r)) else ($stable(sync_feedback_out_r)
        [*5] ##1 $changed(sync_feedback_out_r))) else $error("full rate");
    sync_half_a: assert property (
        up_r >= 4'ha && halve_r && $changed(sync_feedback_out_r) |=>
        $stable(sync_feedback_out_r) [*7]) else $error("half rate");
endmodule

// [verification/ccr_osc_model.sv]
// board references: primary and agent clocks at unlike rates
// assumes core_clk as timebase; both run free like board oscillators
`timescale 1ns/10ps
module ccr_osc_model (
    input wire core_clk,
    output reg primary_osc_input = 1'h0,
    output reg agent_clk_input = 1'h0
);
    reg [3:0] cnt_r = 4'h0;
    // unlike periods, so a wrong source pick shows at the outputs
    always @(posedge core_clk) begin
        cnt_r <= cnt_r == 4'hb ? 4'h0 : cnt_r + 4'h1;
        if (cnt_r[1:0] == 2'h3)
            primary_osc_input <= !primary_osc_input;
        if (cnt_r == 4'h5 || cnt_r == 4'hb)
            agent_clk_input <= !agent_clk_input;
    end
endmodule

// [verification/tb.sv]
// bench: ratio table rows per strap setting, then bus and divider cases
// assumes ccr_clock_ratio, its checker and the oscillator model
`timescale 1ns/10ps
module tb;
    reg core_clk = 1'h0, reset = 1'h1, host_mode_strap = 1'h1;
    reg input_halving_strap = 1'h0;
    reg [3:0] platform_multiplier_field = 4'h6;
    reg [6:0] core_ratio_field = 7'h00;
    reg [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
    reg [31:0] s_axi_wdata = 32'h0;
    reg s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    reg s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    wire primary_osc_input, agent_clk_input, sync_feedback_out_r;
    wire core_locked_r, s_axi_awready, s_axi_wready, s_axi_bvalid;
    wire s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [4:0] bus_clk_out_r, csb_ratio_r;
    wire [6:0] core_ratio_r;
    reg [9:0] rows [0:19];
    reg [31:0] d;
    reg [31:0] e;
    reg [1:0] r;
    reg [6:0] cr;
    reg [4:0] dif;
    integer i, errors = 0, compares = 0, cyc = 0;
    ccr_clock_ratio u_dut (.*);
    ccr_osc_model u_osc (.*);
    always #20 core_clk = ~core_clk;
    task chk(input [31:0] seen, input [31:0] exp, input [31:0] nm);
        begin
            compares = compares + 1;
            if (seen !== exp) begin
                errors = errors + 1;
                $display("Error %0s exp %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task axi(input w, input [3:0] a, input [31:0] wd, input [3:0] s);
        begin
            s_axi_awaddr <= a;
            s_axi_araddr <= a;
            s_axi_wdata <= wd;
            s_axi_wstrb <= s;
            s_axi_awvalid <= w;
            s_axi_wvalid <= w;
            s_axi_bready <= w;
            s_axi_arvalid <= !w;
            s_axi_rready <= !w;
            @(posedge core_clk);
            while (s_axi_bready | s_axi_rready) begin
                if (s_axi_awready) s_axi_awvalid <= 1'h0;
                if (s_axi_wready) s_axi_wvalid <= 1'h0;
                if (s_axi_arready) s_axi_arvalid <= 1'h0;
                if (s_axi_bvalid | s_axi_rvalid) begin
                    r = w ? s_axi_bresp : s_axi_rresp;
                    d = s_axi_rdata;
                    s_axi_bready <= 1'h0;
                    s_axi_rready <= 1'h0;
                end
                @(posedge core_clk);
            end
        end
    endtask
    task rst(input h, input [9:0] w, input [6:0] c);
        begin
            reset <= 1'h1;
            host_mode_strap <= h;
            input_halving_strap <= w[9];
            platform_multiplier_field <= w[8:5];
            core_ratio_field <= c;
            repeat (6) @(posedge core_clk);
            reset <= 1'h0;
            @(posedge core_clk);
        end
    endtask
    task give_verdict;
        begin
            $display("errors %0d compares %0d", errors, compares);
            if (errors == 0 && compares > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    always @(posedge core_clk) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            errors = errors + 1;
            give_verdict;
        end
    end
    initial begin
        // rows: {halving strap, multiplier code, expected ratio}
        rows = '{10'h0c6, 10'h0e7, 10'h108, 10'h129, 10'h14a, 10'h16b,
            10'h18c, 10'h1ad, 10'h1ce, 10'h1ef, 10'h010, 10'h0a0, 10'h244,
            10'h266, 10'h288, 10'h2aa, 10'h2cc, 10'h2ee, 10'h310, 10'h320};
        for (i = 0; i < 20; i = i + 1) begin
            cr = 7'(i * 5);
            rst(i[0], rows[i], cr);
            // pins moved after release must not reach the latched values
            platform_multiplier_field <= ~rows[i][8:5];
            input_halving_strap <= ~rows[i][9];
            core_ratio_field <= ~cr;
            chk(csb_ratio_r, rows[i][4:0], "csb");
            chk(core_ratio_r, cr, "core");
            axi(1'h0, 4'h8, 32'h0, 4'h0);
            e = {9'h0, cr, 3'h0, rows[i][4:0], 4'h0, rows[i][8:5]};
            chk(d, e, "rat");
            repeat (20) @(posedge core_clk);
            chk(core_locked_r, rows[i][4:0] != 5'h00, "lock");
            axi(1'h0, 4'h4, 32'h0, 4'h0);
            e = {28'h0, {2{rows[i][4:0] != 5'h00}}, rows[i][9], i[0]};
            chk(d, e, "st");
        end
        rst(1'h1, 10'h244, 7'h00);
        axi(1'h0, 4'h0, 32'h0, 4'h0);
        chk(d, 32'h0, "occ");
        axi(1'h1, 4'h0, 32'h15, 4'hf);
        axi(1'h1, 4'h0, 32'h1f, 4'he);
        axi(1'h0, 4'h0, 32'h0, 4'h0);
        chk(d, 32'h15, "occ");
        dif = 5'h00;
        repeat (8) @(posedge core_clk);
        repeat (48) begin
            @(posedge core_clk);
            dif = dif | (bus_clk_out_r ^ {5{sync_feedback_out_r}});
        end
        chk(dif, 5'h0a, "div");
        axi(1'h1, 4'h4, 32'h0, 4'hf);
        chk(r, 2'h0, "bro");
        axi(1'h1, 4'hc, 32'h0, 4'hf);
        chk(r, 2'h2, "bre");
        axi(1'h0, 4'hc, 32'h0, 4'h0);
        chk({r, d[29:0]}, 32'h80000000, "rde");
        give_verdict;
    end
endmodule
bind ccr_clock_ratio ccr_chk #(.CORE_W(CORE_W)) u_chk (.*);
